// File: design/elc_top.sv
// Top of the external line controller with flags, requests and events.
`timescale 1ns/10ps
`default_nettype none
module elc_top
   import elc_pkg::*;
#(
   parameter int NPINS = ELC_NPINS
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic clock_source_select_i,
   input wire logic lp32k_tick_i,
   input wire logic standby_i,
   input wire logic [NPINS-1:0] pin_i,
   input wire logic nmi_pin_i,
   input wire elc_pin_cfg_t [NPINS-1:0] pin_cfg_i,
   input wire elc_pin_cfg_t nmi_cfg_i,
   input wire logic [NPINS-1:0] irq_enable_i,
   input wire logic [NPINS-1:0] evt_enable_i,
   input wire elc_wr_t async_wr_i,
   input wire logic [NPINS-1:0] flag_clr_i,
   input wire logic nmi_clr_i,
   output logic [31:0] async_detect_select_o,
   output logic [NPINS-1:0] pin_interrupt_flag_o,
   output logic nonmaskable_pending_flag_o,
   output logic [NPINS-1:0] irq_o,
   output logic [NPINS-1:0] event_o
);
   logic [31:0] async_r;
   logic [31:0] async_nxt;
   logic [NPINS-1:0] flag_r;
   logic [NPINS-1:0] evt_r;
   logic [NPINS-1:0] lock_r;
   logic [NPINS-1:0] hit;
   logic [NPINS-1:0] edg;
   logic [NPINS-1:0] asy_edge;
   logic [NPINS-1:0] pin_d_r;
   logic nmi_r;
   logic nmi_hit;
   logic nmi_reconf;
   logic [2:0] nmi_sense_d_r;
   logic tick;

   // ****************************************************************
   // Detection clock selection.
   // ****************************************************************
   // low power tick
   assign tick = clock_source_select_i ? lp32k_tick_i : 1'b1;

   // ****************************************************************
   // Async detection select register with lane mirroring.
   // ****************************************************************
   always_comb begin
      async_nxt = async_r;
      case (async_wr_i.size)
         ELC_SIZE_BYTE: async_nxt = {4{async_wr_i.data[7:0]}};
         ELC_SIZE_HALF: async_nxt = async_wr_i.addr[1] ?
            {2{async_wr_i.data[31:16]}} : {2{async_wr_i.data[15:0]}};
         ELC_SIZE_WORD: async_nxt = async_wr_i.data;
         default: async_nxt = async_r;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         async_r <= ELC_ASYNC_RST;
      end else if (async_wr_i.en) begin
         async_r <= async_nxt;
      end
   end

   // ****************************************************************
   // Per pin sensing.
   // ****************************************************************
   for (genvar i = 0; i < NPINS; i++) begin : g_pin
      elc_line_sense u_sense (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .tick_i(tick),
         .enable_i(enable_i),
         .pin_i(pin_i[i]),
         .cfg_i(pin_cfg_i[i]),
         .hit_o(hit[i]),
         .edge_o(edg[i])
      );
      // Unclocked path modelled as raw pin change without the tick.
      assign asy_edge[i] = enable_i && (pin_i[i] != pin_d_r[i]);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_d_r <= '0;
      end else begin
         pin_d_r <= pin_i;
      end
   end

   // ****************************************************************
   // Pin flags, set wins over clear.
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_r <= '0;
      end else begin
         flag_r <= (flag_r & ~flag_clr_i) | hit;
      end
   end

   assign irq_o = flag_r & irq_enable_i;

   // ****************************************************************
   // Events and the standby lockout of async detection.
   // ****************************************************************
   // The lockout is armed by the first edge seen in standby; only wake-up
   // or a return to synchronous detection drops it again.
   // lockout until wake-up
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lock_r <= '0;
      end else begin
         for (int k = 0; k < NPINS; k++) begin
            if (!async_r[k] || !standby_i) begin
               lock_r[k] <= 1'b0;
            end else if (asy_edge[k]) begin
               lock_r[k] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_r <= '0;
      end else begin
         for (int k = 0; k < NPINS; k++) begin
            if (async_r[k]) begin
               evt_r[k] <= asy_edge[k] && evt_enable_i[k] &&
                           !(standby_i && lock_r[k]);
            end else begin
               evt_r[k] <= edg[k] && evt_enable_i[k];
            end
         end
      end
   end

   // ****************************************************************
   // Nonmaskable line.
   // ****************************************************************
   elc_line_sense u_nmi (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(tick),
      .enable_i(enable_i),
      .pin_i(nmi_pin_i),
      .cfg_i(nmi_cfg_i),
      .hit_o(nmi_hit),
      .edge_o()
   );

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nmi_sense_d_r <= ELC_SENSE_NONE;
      end else begin
         nmi_sense_d_r <= nmi_cfg_i.sense;
      end
   end

   // A sense change while running is treated as a detection, so software
   // has to clear the flag after any sense change made while enabled.
   // reconfig false flag
   assign nmi_reconf = enable_i && (nmi_sense_d_r != nmi_cfg_i.sense);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nmi_r <= 1'b0;
      end else if (nmi_hit || nmi_reconf) begin
         nmi_r <= 1'b1;
      end else if (nmi_clr_i) begin
         nmi_r <= 1'b0;
      end
   end

   assign async_detect_select_o = async_r;
   assign pin_interrupt_flag_o = flag_r;
   assign nonmaskable_pending_flag_o = nmi_r;
   assign event_o = evt_r;
endmodule
`default_nettype wire

// File: design/elc_pkg.sv
// Package with constants and types of the external line controller.
// Function
// - Byte write to async select copies the byte into all four lanes.
// - Upper halfword write to async select also writes the lower half.
// - Lower halfword write to async select also writes the upper half.
// - Filtered low, rising or both sensing may flag at once on enable.
// - Changing nonmaskable sense while running may raise a false flag.
// - Async detection in standby gives an event only for the first edge.
// - Later standby edges on that pin give no event until wake-up.
// - Async select bit zero means synchronous clocked edge detection.
// - Clock source select one runs detection from the 32 kHz tick.
package elc_pkg;
   localparam int ELC_NPINS = 16;
   localparam logic [31:0] ELC_ASYNC_RST = 32'h0000_0000;
   localparam logic [1:0] ELC_SIZE_BYTE = 2'h0;
   localparam logic [1:0] ELC_SIZE_HALF = 2'h1;
   localparam logic [1:0] ELC_SIZE_WORD = 2'h2;
   localparam int ELC_FILT_LEN = 3;
   // Sense encodings of pin_sense_config.
   localparam logic [2:0] ELC_SENSE_NONE = 3'h0;
   localparam logic [2:0] ELC_SENSE_RISE = 3'h1;
   localparam logic [2:0] ELC_SENSE_FALL = 3'h2;
   localparam logic [2:0] ELC_SENSE_BOTH = 3'h3;
   localparam logic [2:0] ELC_SENSE_HIGH = 3'h4;
   localparam logic [2:0] ELC_SENSE_LOW = 3'h5;

   typedef struct packed {
      logic en;
      logic [1:0] size;
      logic [1:0] addr;
      logic [31:0] data;
   } elc_wr_t;

   typedef struct packed {
      logic [2:0] sense;
      logic filt_en;
   } elc_pin_cfg_t;
endpackage

// File: design/elc_line_sense.sv
// One line sensor: sampling, optional filter and sense match.
`timescale 1ns/10ps
`default_nettype none
module elc_line_sense
   import elc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic enable_i,
   input wire logic pin_i,
   input wire elc_pin_cfg_t cfg_i,
   output logic hit_o,
   output logic edge_o
);
   logic [ELC_FILT_LEN-1:0] samp_r;
   logic filt_r;
   logic prev_r;
   logic prim_r;
   logic cur;
   logic rise;
   logic fall;

   // ****************************************************************
   // Sampling on the selected detection tick.
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         samp_r <= '0;
      end else if (tick_i) begin
         samp_r <= {samp_r[ELC_FILT_LEN-2:0], pin_i};
      end
   end

   // Majority filter; it starts from zero so enabling it can look like an
   // edge or a low level.
   // spurious flag source
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         filt_r <= 1'b0;
      end else if (tick_i) begin
         filt_r <= (samp_r[0] & samp_r[1]) | (samp_r[1] & samp_r[2]) |
                   (samp_r[0] & samp_r[2]);
      end
   end

   assign cur = cfg_i.filt_en ? filt_r : samp_r[0];

   // The rising check skips the priming when the filter is on, so a filtered
   // line sees a stale history on the first tick after enable.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_r <= 1'b0;
         prim_r <= 1'b0;
      end else if (!enable_i) begin
         prim_r <= 1'b0;
      end else if (tick_i) begin
         prev_r <= cur;
         prim_r <= 1'b1;
      end
   end

   assign rise = tick_i && enable_i && cur && !prev_r &&
                 (prim_r || cfg_i.filt_en);
   assign fall = tick_i && enable_i && !cur && prev_r && prim_r;

   always_comb begin
      case (cfg_i.sense)
         ELC_SENSE_RISE: hit_o = rise;
         ELC_SENSE_FALL: hit_o = fall;
         ELC_SENSE_BOTH: hit_o = rise | fall;
         ELC_SENSE_HIGH: hit_o = tick_i && enable_i && cur;
         ELC_SENSE_LOW: hit_o = tick_i && enable_i && !cur;
         default: hit_o = 1'b0;
      endcase
   end

   assign edge_o = rise | fall;
endmodule
`default_nettype wire

// File: tb/elc_asserts.sv
// Port checker of the external line controller, bound into the top.
`timescale 1ns/10ps
`default_nettype none
module elc_asserts
   import elc_pkg::*;
#(
   parameter int NPINS = ELC_NPINS
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic standby_i,
   input wire elc_pin_cfg_t nmi_cfg_i,
   input wire logic [NPINS-1:0] irq_enable_i,
   input wire elc_wr_t async_wr_i,
   input wire logic [NPINS-1:0] flag_clr_i,
   input wire logic nmi_clr_i,
   input wire logic [31:0] async_detect_select_o,
   input wire logic [NPINS-1:0] pin_interrupt_flag_o,
   input wire logic nonmaskable_pending_flag_o,
   input wire logic [NPINS-1:0] irq_o,
   input wire logic [NPINS-1:0] event_o
);
   // ****
   // Properties
   // ****
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [1:0] sb_cnt_r;
   // Counts line 0 events in one standby stay on async detection.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sb_cnt_r <= 2'h0;
      end else if (!standby_i) begin
         sb_cnt_r <= 2'h0;
      end else if (event_o[0] && async_detect_select_o[0]
                   && sb_cnt_r != 2'h3) begin
         sb_cnt_r <= sb_cnt_r + 2'h1;
      end
   end
   a_byte_lanes: assert property (async_wr_i.en &&
      async_wr_i.size == ELC_SIZE_BYTE |=>
      async_detect_select_o == {4{$past(async_wr_i.data[7:0])}})
      else $error("byte write not copied to every lane");
   a_half_upper: assert property (async_wr_i.en && async_wr_i.addr[1] &&
      async_wr_i.size == ELC_SIZE_HALF |=>
      async_detect_select_o == {2{$past(async_wr_i.data[31:16])}})
      else $error("upper half write not mirrored");
   a_half_lower: assert property (async_wr_i.en &&
      !async_wr_i.addr[1] && async_wr_i.size == ELC_SIZE_HALF |=>
      async_detect_select_o == {2{$past(async_wr_i.data[15:0])}})
      else $error("lower half write not mirrored");
   a_word_write: assert property (async_wr_i.en &&
      async_wr_i.size == ELC_SIZE_WORD |=>
      async_detect_select_o == $past(async_wr_i.data))
      else $error("word write not stored");
   a_irq_gate: assert property (irq_o ==
      (pin_interrupt_flag_o & irq_enable_i))
      else $error("request differs from flag and enable");
   a_flag_hold: assert property (($past(pin_interrupt_flag_o) &
      ~pin_interrupt_flag_o & ~$past(flag_clr_i)) == '0)
      else $error("pin flag fell without a clear");
   a_nmi_clear: assert property (nmi_clr_i && !enable_i |=>
      !nonmaskable_pending_flag_o)
      else $error("nonmaskable flag not cleared");
   a_nmi_false: assert property (enable_i && $changed(nmi_cfg_i.sense)
      |=> nonmaskable_pending_flag_o)
      else $error("sense change gave no nonmaskable flag");
   a_standby_once: assert property (sb_cnt_r < 2'h2)
      else $error("second standby event before wake-up");
   cover property (nonmaskable_pending_flag_o);
   cover property (|irq_o);
   cover property (sb_cnt_r == 2'h1);
endmodule
bind elc_top elc_asserts #(.NPINS(NPINS)) u_chk (.clk_i(clk_i),
   .rst_n_i(rst_n_i), .enable_i(enable_i), .standby_i(standby_i),
   .nmi_cfg_i(nmi_cfg_i), .irq_enable_i(irq_enable_i),
   .async_wr_i(async_wr_i), .flag_clr_i(flag_clr_i), .nmi_clr_i(nmi_clr_i),
   .async_detect_select_o(async_detect_select_o),
   .pin_interrupt_flag_o(pin_interrupt_flag_o),
   .nonmaskable_pending_flag_o(nonmaskable_pending_flag_o),
   .irq_o(irq_o), .event_o(event_o));
`default_nettype wire

// File: tb/elc_line_model.sv
// Model of the external lines that feed the controller.
`timescale 1ns/10ps
`default_nettype none
module elc_line_model (
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic [15:0] lvl_i,
   output logic [15:0] pin_o
);
   // ****
   // Line driver
   // ****
   logic [15:0] lfsr_r;
   // clean synchronous levels
   // Lines move just after a falling edge, never near the sampling edge.
   initial begin
      lfsr_r = 16'hace1;
      pin_o = 16'h0000;
      forever begin
         @(negedge clk_i);
         #1;
         lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12]};
         pin_o = run_i ? lfsr_r : lvl_i;
      end
   end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking testbench of the external line controller.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import elc_pkg::*;
   // ****
   // Harness
   // ****
   logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, cks = 1'b0, tk = 1'b0;
   logic sb = 1'b0, run = 1'b0, nclr = 1'b0, npin = 1'b0, nflag;
   logic [15:0] lvl = 16'h000a, irqen = '0, evten = '0, fclr = '0;
   logic [15:0] pins, flag, irq, evt;
   logic [31:0] asel, e;
   elc_pin_cfg_t [15:0] cfg = '0;
   elc_pin_cfg_t ncfg = '0;
   elc_wr_t wr = '0;
   int n_fail = 0, checked = 0, c, i;
   initial begin
      forever #5 clk = ~clk;
   end
   elc_line_model u_lines (.clk_i(clk), .run_i(run), .lvl_i(lvl),
      .pin_o(pins));
   elc_top #(.NPINS(16)) dut (.clk_i(clk), .rst_n_i(rst_n), .enable_i(en),
      .clock_source_select_i(cks), .lp32k_tick_i(tk), .standby_i(sb),
      .pin_i(pins), .nmi_pin_i(npin), .pin_cfg_i(cfg), .nmi_cfg_i(ncfg),
      .irq_enable_i(irqen), .evt_enable_i(evten), .async_wr_i(wr),
      .flag_clr_i(fclr), .nmi_clr_i(nclr), .async_detect_select_o(asel),
      .pin_interrupt_flag_o(flag), .nonmaskable_pending_flag_o(nflag),
      .irq_o(irq), .event_o(evt));
   task automatic final_report();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   function automatic logic [31:0] exp_sel(input logic [31:0] o,
      input elc_wr_t w);
      case (w.size)
         ELC_SIZE_BYTE: return {4{w.data[7:0]}};
         ELC_SIZE_HALF: return w.addr[1] ? {2{w.data[31:16]}}
                                         : {2{w.data[15:0]}};
         ELC_SIZE_WORD: return w.data;
         default: return o;
      endcase
   endfunction
   task automatic wait_flag(input int p);
      int k;
      for (k = 0; k < 40 && flag[p] !== 1'b1; k++) @(negedge clk);
      if (k == 40) begin
         n_fail++;
         final_report();
      end
   endtask
   task automatic count_evt(input int n, output int cnt);
      cnt = 0;
      repeat (n) begin
         lvl[0] = ~lvl[0];
         repeat (3) begin
            @(negedge clk);
            if (evt[0] === 1'b1) cnt++;
         end
      end
   endtask
   initial begin
      void'($urandom(87513));
      tick(8);
      rst_n = 1'b1;
      tick(1);
      e = asel;
      for (i = 0; i < 24; i++) begin
         wr = '{1'b1, 2'($urandom_range(3)), 2'($urandom), 32'($urandom)};
         e = exp_sel(e, wr);
         tick(1);
         cmp(asel, e);
      end
      wr.en = 1'b0;
      cfg[1] = '{ELC_SENSE_RISE, 1'b1};
      cfg[2] = '{ELC_SENSE_BOTH, 1'b1};
      cfg[3] = '{ELC_SENSE_LOW, 1'b1};
      cfg[4] = '{ELC_SENSE_RISE, 1'b0};
      en = 1'b1;
      tick(5);
      cmp(flag[1], 1'b1);
      fclr = 16'hffff;
      tick(1);
      fclr = '0;
      cmp(flag, 32'h0);
      irqen = 16'hffff;
      lvl[4] = 1'b1;
      wait_flag(4);
      cmp(irq, 32'h10);
      fclr[4] = 1'b1;
      tick(1);
      fclr = '0;
      tick(3);
      cmp(flag[4], 1'b0);
      ncfg.sense = ELC_SENSE_RISE;
      tick(2);
      cmp(nflag, 1'b1);
      nclr = 1'b1;
      tick(1);
      nclr = 1'b0;
      cmp(nflag, 1'b0);
      cfg[6] = '{ELC_SENSE_RISE, 1'b0};
      cks = 1'b1;
      lvl[6] = 1'b1;
      tick(12);
      cmp(flag[6], 1'b0);
      repeat (6) begin
         tk = 1'b1;
         tick(1);
         tk = 1'b0;
         tick(2);
      end
      cmp(flag[6], 1'b1);
      cks = 1'b0;
      cfg[0] = '{ELC_SENSE_BOTH, 1'b0};
      evten[0] = 1'b1;
      wr = '{1'b1, ELC_SIZE_WORD, 2'h0, 32'h0000_0001};
      tick(1);
      wr.en = 1'b0;
      sb = 1'b1;
      tick(3);
      count_evt(4, c);
      cmp(c, 1);
      sb = 1'b0;
      tick(3);
      count_evt(4, c);
      cmp(c, 4);
      run = 1'b1;
      repeat (200) begin
         cfg[$urandom_range(15)] = '{3'($urandom_range(5)), 1'($urandom)};
         ncfg.sense = 3'($urandom_range(5));
         irqen = 16'($urandom);
         npin = 1'($urandom);
         fclr = 16'($urandom);
         tick(1);
         cmp(irq, flag & irqen);
      end
      run = 1'b0;
      en = 1'b0;
      nclr = 1'b1;
      tick(1);
      nclr = 1'b0;
      cmp(nflag, 1'b0);
      final_report();
   end
endmodule
`default_nettype wire
